/* File: rtl/cgq_regs.vh */
// Constants for the channel-gain scan queue: sizes, codes and timing counts.
// Assumes a single 100 MHz logic clock; no software-visible registers exist.
`ifndef CGQ_REGS_VH
`define CGQ_REGS_VH

`define CGQ_DEPTH 64
`define CGQ_IDX_W 6
`define CGQ_CH_W 6
`define CGQ_GAIN_W 2
`define CGQ_FIFO_DEPTH 32
`define CGQ_FIFO_AW 5

// Fastest single-channel conversion rate, and the clock it is measured against
`define CGQ_MAX_RATE_KSPS 333
`define CGQ_CLK_MHZ 100
// Least strobe spacing in clock cycles: 100000 / 333 = 300, sized to the gap counter
`define CGQ_MIN_STROBE_CYC 9'h12C
`define CGQ_GAP_W 9

// Sequencer states, one-hot
`define CGQ_ST_IDLE 3'h1
`define CGQ_ST_ARMED 3'h2
`define CGQ_ST_BURST 3'h4

`endif

/* File: rtl/scan_fifo.v */
// First-word-fall-through FIFO held in flip-flops.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module scan_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire sys_clk,
   input wire rst,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_q;
   reg [AW-1:0] rd_ptr_q;
   reg [AW:0] count_q;
   wire push;
   wire pop;

   assign in_ready = (count_q != DEPTH[AW:0]);
   assign out_valid = (count_q != {(AW+1){1'b0}});
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem_q[rd_ptr_q];

   always @(posedge sys_clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   // Pointers wrap by index so DEPTH need not be a power of two
   always @(posedge sys_clk) begin
      if (rst) begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end

endmodule // scan_fifo

`default_nettype wire

/* File: rtl/channel_gain_scan_queue.v */
// Channel-gain scan queue: a 64-entry table of channel and gain, stepped by
// conversion strobes, feeding conversion requests to the analog front end.
// Assumes pacer and burst strobes are one-cycle pulses synchronous to sys_clk
// and that the host loads the table only while acquisition is disabled.
`timescale 1ns/10ps
`default_nettype none
`include "cgq_regs.vh"

////////////////////////////////////////////////////////////////////////////////
module channel_gain_scan_queue #(
   parameter DEPTH = `CGQ_DEPTH,
   parameter IDX_W = `CGQ_IDX_W,
   parameter CH_W = `CGQ_CH_W,
   parameter GAIN_W = `CGQ_GAIN_W,
   parameter FIFO_DEPTH = `CGQ_FIFO_DEPTH,
   parameter FIFO_AW = `CGQ_FIFO_AW
) (
   input wire sys_clk,
   input wire rst,
   input wire acq_enable,
   input wire burst_mode,
   input wire diff_mode,
   input wire [IDX_W-1:0] scan_last,
   input wire load_valid,
   output wire load_ready,
   input wire [IDX_W-1:0] load_index,
   input wire [CH_W-1:0] load_channel,
   input wire [GAIN_W-1:0] load_gain,
   input wire pacer_pulse,
   input wire burst_pulse,
   output wire conv_valid,
   input wire conv_ready,
   output wire [CH_W-1:0] conv_channel,
   output wire [GAIN_W-1:0] conv_gain,
   output wire [IDX_W-1:0] conv_index,
   output wire [IDX_W-1:0] scan_index,
   output wire scan_busy,
   output wire scan_wrap,
   output wire overrun,
   output wire rate_fault
);

   localparam ENTRY_W = CH_W + GAIN_W;
   localparam CMD_W = IDX_W + CH_W + GAIN_W;
   localparam [2:0] ST_IDLE = `CGQ_ST_IDLE;
   localparam [2:0] ST_ARMED = `CGQ_ST_ARMED;
   localparam [2:0] ST_BURST = `CGQ_ST_BURST;
   localparam [`CGQ_GAP_W-1:0] MIN_GAP = `CGQ_MIN_STROBE_CYC - 9'h001;

   reg [ENTRY_W-1:0] table_q [0:DEPTH-1];
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [IDX_W-1:0] idx_q;
   reg [IDX_W-1:0] idx_d;
   reg wrap_q;
   reg overrun_q;
   reg rate_fault_q;
   reg [`CGQ_GAP_W-1:0] gap_q;

   wire load_take;
   wire [ENTRY_W-1:0] entry;
   wire [CH_W-1:0] entry_ch;
   wire [CH_W-1:0] mux_ch;
   wire [GAIN_W-1:0] entry_gain;
   wire strobe;
   wire take;
   wire drop;
   wire last;
   wire fifo_in_ready;
   wire [CMD_W-1:0] fifo_in;
   wire [CMD_W-1:0] fifo_out;

   ////////////////////////////////////////////////////////////////////////////
   // Queue table

   // Table writes are refused while scanning so a scan never sees a half-
   // rewritten sequence
   assign load_ready = (state_q == ST_IDLE);
   assign load_take = load_valid & load_ready;

   genvar e;
   generate
      for (e = 0; e < DEPTH; e = e + 1) begin : g_entry
         always @(posedge sys_clk) begin
            if (load_take && load_index == e[IDX_W-1:0]) begin
               table_q[e] <= {load_channel, load_gain};
            end
         end
      end
   endgenerate

   assign entry = table_q[idx_q];
   assign entry_ch = entry[ENTRY_W-1:GAIN_W];
   assign entry_gain = entry[GAIN_W-1:0];
   // Differential pairs only reach 32 inputs, so the top select bit is dropped
   assign mux_ch = diff_mode ? {1'b0, entry_ch[CH_W-2:0]} : entry_ch;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer

   // Gated by acq_enable: a strobe in the cycle acquisition stops would push a
   // request without advancing the index
   assign strobe = acq_enable
                 & ((state_q == ST_ARMED && !burst_mode && pacer_pulse)
                 | (state_q == ST_BURST && burst_pulse));
   // A strobe that meets a full FIFO is lost and the entry is retried, so
   // the sequence stays in order at the cost of one missed sample
   assign take = strobe & fifo_in_ready;
   assign drop = strobe & ~fifo_in_ready;
   // Compare with >= so a shortened scan_last mid-run still wraps
   assign last = (idx_q >= scan_last);

   always @* begin
      state_d = state_q;
      idx_d = idx_q;
      case (state_q)
         ST_IDLE: begin
            idx_d = {IDX_W{1'b0}};
            if (acq_enable) begin
               state_d = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (!acq_enable) begin
               state_d = ST_IDLE;
            end else if (burst_mode && pacer_pulse) begin
               state_d = ST_BURST;
            end else if (take) begin
               idx_d = last ? {IDX_W{1'b0}} : idx_q + 1'b1;
            end
         end
         ST_BURST: begin
            if (!acq_enable) begin
               state_d = ST_IDLE;
            end else if (take) begin
               idx_d = last ? {IDX_W{1'b0}} : idx_q + 1'b1;
               if (last) begin
                  state_d = ST_ARMED;
               end
            end
         end
         default: begin
            state_d = ST_IDLE;
            idx_d = {IDX_W{1'b0}};
         end
      endcase
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
         idx_q <= {IDX_W{1'b0}};
         wrap_q <= 1'b0;
      end else begin
         state_q <= state_d;
         idx_q <= idx_d;
         wrap_q <= take & last;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status: lost strobes and strobes faster than the front end can convert

   always @(posedge sys_clk) begin
      if (rst) begin
         overrun_q <= 1'b0;
         rate_fault_q <= 1'b0;
         gap_q <= MIN_GAP;
      end else begin
         if (drop) begin
            overrun_q <= 1'b1;
         end else if (state_q == ST_IDLE) begin
            overrun_q <= 1'b0;
         end
         // Spacing below 300 cycles exceeds the 333 ksps front-end limit
         if (take && gap_q < MIN_GAP) begin
            rate_fault_q <= 1'b1;
         end else if (state_q == ST_IDLE) begin
            rate_fault_q <= 1'b0;
         end
         if (take) begin
            gap_q <= {`CGQ_GAP_W{1'b0}};
         end else if (state_q == ST_IDLE) begin
            // A fresh scan starts with a full gap so its first take never faults
            gap_q <= MIN_GAP;
         end else if (gap_q < MIN_GAP) begin
            gap_q <= gap_q + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Conversion request buffer toward the front end

   // Every strobe that finds FIFO room is accepted in its own cycle, so back-to-back single-channel
   // conversions run at full strobe rate until the FIFO fills
   assign fifo_in = {idx_q, mux_ch, entry_gain};

   scan_fifo #(
      .WIDTH(CMD_W),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_req_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .in_valid(take),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(conv_valid),
      .out_ready(conv_ready),
      .out_data(fifo_out)
   );

   assign conv_index = fifo_out[CMD_W-1:CH_W+GAIN_W];
   assign conv_channel = fifo_out[CH_W+GAIN_W-1:GAIN_W];
   assign conv_gain = fifo_out[GAIN_W-1:0];
   assign scan_index = idx_q;
   assign scan_busy = (state_q == ST_BURST);
   assign scan_wrap = wrap_q;
   assign overrun = overrun_q;
   assign rate_fault = rate_fault_q;

endmodule // channel_gain_scan_queue

`default_nettype wire

/* File: testbench/channel_gain_scan_queue_asserts.sv */
// Port checker for the scan queue, bound into its top module.
// Assumes one clock and synchronous active-high rst.
`timescale 1ns/10ps
`default_nettype none
module cgq_checker (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic acq_enable,
   input wire logic burst_mode,
   input wire logic diff_mode,
   input wire logic pacer_pulse,
   input wire logic conv_ready,
   input wire logic [5:0] scan_last,
   input wire logic load_ready,
   input wire logic conv_valid,
   input wire logic [5:0] conv_channel,
   input wire logic [5:0] conv_index,
   input wire logic [5:0] scan_index,
   input wire logic scan_busy,
   input wire logic scan_wrap,
   input wire logic overrun
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_load_block:
      assert property (acq_enable |=> !load_ready) else $error("load open");
   a_idle_home:
      assert property (!acq_enable ##1 !acq_enable |=> load_ready && scan_index == 6'h00)
         else $error("no idle");
   a_diff_pair:
      assert property (conv_valid && diff_mode |-> !conv_channel[5]) else $error("diff bit");
   a_wrap_home:
      assert property (scan_wrap |-> scan_index == 6'h00 && $past(scan_index) == $past(scan_last))
         else $error("bad wrap");
   a_index_step:
      assert property (!$stable(scan_index) |->
         scan_index == $past(scan_index) + 6'h01 || scan_index == 6'h00) else $error("index jump");
   a_req_hold:
      assert property (conv_valid && !conv_ready && acq_enable |=>
         conv_valid && $stable({conv_channel, conv_index})) else $error("request moved");
   a_burst_start:
      assert property ($rose(scan_busy) |-> $past(pacer_pulse) && $past(burst_mode))
         else $error("stray burst");
   a_paced_push:
      assert property (pacer_pulse && !burst_mode && acq_enable && !load_ready && !scan_busy
         |=> conv_valid) else $error("no request");
   c_wrap: cover property (scan_wrap);
   c_burst_done: cover property ($fell(scan_busy));
   c_overrun: cover property ($rose(overrun));
endmodule // cgq_checker
bind channel_gain_scan_queue cgq_checker i_chk (.sys_clk(sys_clk), .rst(rst),
   .acq_enable(acq_enable), .burst_mode(burst_mode), .diff_mode(diff_mode),
   .pacer_pulse(pacer_pulse), .conv_ready(conv_ready), .scan_last(scan_last),
   .load_ready(load_ready), .conv_valid(conv_valid), .conv_channel(conv_channel),
   .conv_index(conv_index), .scan_index(scan_index), .scan_busy(scan_busy),
   .scan_wrap(scan_wrap), .overrun(overrun));
`default_nettype wire

/* File: testbench/front_end_model.sv */
// Front end model: takes conversion requests, sometimes slowly.
// Assumes one clock; stall holds it off entirely.
`timescale 1ns/10ps
`default_nettype none
module front_end_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic stall,
   output logic conv_ready
);
   // Random refusals stand for a converter still busy with the last sample
   always @(posedge sys_clk) begin
      #1 conv_ready = !rst && !stall && $urandom % 4 != 0;
   end
endmodule // front_end_model
`default_nettype wire

/* File: testbench/channel_gain_scan_queue_tb.sv */
// Bench for the scan queue: random table, paced, burst and overrun runs.
// Assumes the front end model pops requests and the checker is bound.
`timescale 1ns/10ps
`default_nettype none
module channel_gain_scan_queue_tb;
   logic sys_clk, rst, acq_enable, burst_mode, diff_mode, load_valid, load_ready, stall;
   logic pacer_pulse, burst_pulse, conv_valid, conv_ready, in_burst;
   logic scan_busy, scan_wrap, overrun, rate_fault;
   logic [5:0] scan_last, load_index, load_channel, conv_channel, conv_index, scan_index;
   logic [1:0] load_gain, conv_gain;
   logic [7:0] tbl [64];
   logic [13:0] exp_q [$];
   int failures, tests_run, cyc, nxt, i;
   int pops, base, wraps, exp_wraps;
   channel_gain_scan_queue i_dut (.sys_clk(sys_clk), .rst(rst), .acq_enable(acq_enable),
      .burst_mode(burst_mode), .diff_mode(diff_mode), .scan_last(scan_last),
      .load_valid(load_valid), .load_ready(load_ready), .load_index(load_index),
      .load_channel(load_channel), .load_gain(load_gain), .pacer_pulse(pacer_pulse),
      .burst_pulse(burst_pulse), .conv_valid(conv_valid), .conv_ready(conv_ready),
      .conv_channel(conv_channel), .conv_gain(conv_gain), .conv_index(conv_index),
      .scan_index(scan_index), .scan_busy(scan_busy), .scan_wrap(scan_wrap),
      .overrun(overrun), .rate_fault(rate_fault));
   front_end_model i_fe (.sys_clk(sys_clk), .rst(rst), .stall(stall), .conv_ready(conv_ready));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         conclude();
      end
      if (!rst && scan_wrap === 1'b1) wraps++;
      if (!rst && conv_valid === 1'b1 && conv_ready) begin
         pops++;
         if (exp_q.size() == 0) check("spare pop", 16'h0001, 16'h0000);
         else check("pop", {conv_index, conv_channel, conv_gain}, exp_q.pop_front());
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic check(input string what, input logic [15:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   function automatic logic [13:0] word_of(input int idx);
      return {idx[5:0], tbl[idx][7:2] & {~diff_mode, 5'h1F}, tbl[idx][1:0]};
   endfunction
   // A strobe that meets a full queue is dropped and the same entry retried
   task automatic strobe(input logic brst, input int gap);
      if (brst) burst_pulse = 1'b1;
      else pacer_pulse = 1'b1;
      if ((brst ? in_burst : !burst_mode) && exp_q.size() < 32) begin
         exp_q.push_back(word_of(nxt));
         if (nxt == scan_last) exp_wraps++;
         in_burst = in_burst && nxt != scan_last;
         nxt = (nxt == scan_last) ? 0 : nxt + 1;
      end else if (!brst && burst_mode) in_burst = 1'b1;
      tick(1);
      pacer_pulse = 1'b0;
      burst_pulse = 1'b0;
      tick(gap);
   endtask
   task automatic idle();
      tick(20);
      check("drained", 16'(exp_q.size()), 0);
      check("wraps", 16'(wraps), 16'(exp_wraps));
      acq_enable = 1'b0;
      tick(2);
      check("idle", {load_ready, overrun, rate_fault, scan_index}, 16'h0100);
      nxt = 0;
      in_burst = 1'b0;
   endtask
   initial begin
      i = $urandom(46);
      {rst, acq_enable, burst_mode, diff_mode, pacer_pulse, burst_pulse, stall} = 7'h40;
      {in_burst, load_valid, scan_last, load_index, load_channel, load_gain} = 22'h000000;
      tick(12);
      rst = 1'b0;
      check("reset", {load_ready, conv_valid, scan_busy, scan_index}, 16'h0100);
      load_valid = 1'b1;
      for (i = 0; i < 64; i++) begin
         load_index = i[5:0];
         if (i == 1) {load_channel, load_gain} = tbl[0];
         else {load_channel, load_gain} = 8'($urandom);
         tbl[i] = {load_channel, load_gain};
         tick(1);
      end
      load_valid = 1'b0;
      scan_last = 6'($urandom % 7 + 1);
      acq_enable = 1'b1;
      tick(1);
      load_valid = 1'b1;
      load_index = 6'h00;
      load_channel = ~tbl[0][7:2];
      tick(1);
      check("busy load", 16'(load_ready), 0);
      load_valid = 1'b0;
      for (i = 0; i < 2 * scan_last + 3; i++) strobe(1'b0, 300);
      check("rate", 16'(rate_fault), 0);
      idle();
      diff_mode = 1'b1;
      base = pops;
      burst_mode = 1'b1;
      scan_last = 6'h3F;
      acq_enable = 1'b1;
      tick(1);
      strobe(1'b0, 1);
      check("burst on", 16'(scan_busy), 1);
      for (i = 0; i < 66; i++) strobe(i != 9, 2);
      check("burst off", 16'(scan_busy), 0);
      idle();
      check("scan depth", 16'(pops - base), 16'h0040);
      {burst_mode, diff_mode, stall, acq_enable} = 4'h3;
      tick(2);
      for (i = 0; i < 34; i++) strobe(1'b0, 1);
      check("full", {overrun, rate_fault}, 16'h0003);
      stall = 1'b0;
      tick(60);
      idle();
      conclude();
   end
endmodule // channel_gain_scan_queue_tb
`default_nettype wire
